// ===== include/trim_swap_pkg.sv
package trim_swap_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_REFERENCE_TRIM = 10'h07C;
   localparam logic [9:0] IDX_TERM_A_TRIM    = 10'h07E;
   localparam logic [9:0] IDX_TERM_B_TRIM    = 10'h07F;
   localparam logic [9:0] IDX_TERM_C_TRIM    = 10'h080;
   localparam logic [9:0] IDX_TERM_D_TRIM    = 10'h081;
   localparam logic [9:0] IDX_SWAP_OVERLAP   = 10'h09A;
   localparam logic [9:0] IDX_SWAP_STEER     = 10'h09B;
   localparam logic [9:0] IDX_NOISE_INJ      = 10'h09D;
   localparam logic [9:0] IDX_SWAP_CONTROL   = 10'h0A0;
   localparam logic [9:0] IDX_SWAP_STATUS    = 10'h0A1;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and field positions
   localparam logic [7:0] RST_TRIM        = 8'h00;
   localparam logic [7:0] RST_OVERLAP     = 8'h08;
   localparam logic [7:0] RST_STEER       = 8'h07;
   localparam logic [7:0] RST_NOISE       = 8'h00;
   localparam int         REF_FIELD_MSB   = 3;
   localparam int         DLY_FIELD_MSB   = 4;
   localparam int         CTRL_CAL_EN_BIT = 0;
   localparam int         STAT_BUSY_BIT   = 0;
   localparam int         STAT_OVL_BIT    = 1;
   localparam int         STAT_SEL_BIT    = 2;
   localparam int         STAT_LOCK_BIT   = 3;

   ////////////////////////////////////////////////////////////////////////
   // Overlap length is base plus twice the programmed delay
   localparam int         OVERLAP_BASE    = 4;
   localparam int         OVERLAP_SCALE   = 2;
   localparam int         SWAP_CNT_W      = 7;

   typedef enum logic [1:0] {
      SWAP_IDLE    = 2'b00,
      SWAP_OVERLAP = 2'b01,
      SWAP_STEER   = 2'b11
   } swap_state_t;

   // Factory trims, also the trim outputs
   typedef struct packed {
      logic [3:0] reference;
      logic [7:0] term_a;
      logic [7:0] term_b;
      logic [7:0] term_c;
      logic [7:0] term_d;
   } trim_set_t;

   // Swap timing outputs
   typedef struct packed {
      logic busy;
      logic overlap;
      logic steer_sel;
   } swap_view_t;

   function automatic logic [SWAP_CNT_W-1:0] overlap_cycles(input logic [4:0] dly);
      overlap_cycles = SWAP_CNT_W'(OVERLAP_BASE + OVERLAP_SCALE * int'(dly));
   endfunction

endpackage

// ===== hw/swap_timer.sv
`timescale 1ns/1ps
module swap_timer
   import trim_swap_pkg::*;
#(
   parameter int DLY_W = 5
) (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_reset,
   // Swap request and delays
   input  wire logic                  i_start,
   input  wire logic [DLY_W-1:0]      i_overlap_dly,
   input  wire logic [DLY_W-1:0]      i_steer_dly,
   // Timing outputs
   output trim_swap_pkg::swap_view_t  o_view
);
   import trim_swap_pkg::*;

   initial begin
      if (DLY_W != DLY_FIELD_MSB + 1) $error("DLY_W must match the delay field");
   end

   swap_state_t            state_r;
   logic [SWAP_CNT_W-1:0]  cnt_r;
   logic [SWAP_CNT_W-1:0]  dur_r;
   logic [DLY_W-1:0]       steer_r;
   logic                   sel_r;
   logic                   steered_r;
   logic                   accept;

   assign accept = i_start && (state_r == SWAP_IDLE);

   // Sequencer; a start during a swap is dropped, delays latched at start
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state_r <= SWAP_IDLE;
         cnt_r   <= '0;
         dur_r   <= '0;
         steer_r <= '0;
      end else begin
         case (state_r)
            SWAP_IDLE: begin
               if (accept) begin
                  state_r <= SWAP_OVERLAP;
                  cnt_r   <= '0;
                  dur_r   <= overlap_cycles(i_overlap_dly);
                  steer_r <= i_steer_dly;
               end
            end
            SWAP_OVERLAP: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == dur_r - 1'b1) begin
                  state_r <= (steered_r || cnt_r == SWAP_CNT_W'(steer_r)) ?
                             SWAP_IDLE : SWAP_STEER;
               end
            end
            SWAP_STEER: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == SWAP_CNT_W'(steer_r)) state_r <= SWAP_IDLE;
            end
            default: state_r <= SWAP_IDLE;
         endcase
      end
   end

   // Output stream select flips once per swap, steer delay plus one cycle after start
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sel_r     <= 1'b0;
         steered_r <= 1'b0;
      end else if (accept) begin
         steered_r <= 1'b0;
      end else if (state_r != SWAP_IDLE && !steered_r &&
                   cnt_r == SWAP_CNT_W'(steer_r)) begin
         sel_r     <= ~sel_r;
         steered_r <= 1'b1;
      end
   end

   assign o_view.busy      = (state_r != SWAP_IDLE);
   assign o_view.overlap   = (state_r == SWAP_OVERLAP);
   assign o_view.steer_sel = sel_r;

   // Checks on swap timing
   a_overlap_length: assert property (@(posedge i_clk) disable iff (i_reset)
      $fell(o_view.overlap) |-> cnt_r == dur_r)
      else $error("overlap length differs from four plus twice the delay");
   a_steer_moment: assert property (@(posedge i_clk) disable iff (i_reset)
      $changed(sel_r) |-> $past(cnt_r) == SWAP_CNT_W'(steer_r))
      else $error("stream select flipped at the wrong count");
   a_busy_drops_start: assert property (@(posedge i_clk) disable iff (i_reset)
      (o_view.busy && i_start) |=> $stable(dur_r) && $stable(steer_r))
      else $error("start during a swap changed its timing");
   c_swap_done: cover property (@(posedge i_clk) disable iff (i_reset)
      $fell(o_view.busy));
   c_late_steer: cover property (@(posedge i_clk) disable iff (i_reset)
      state_r == SWAP_STEER);
   c_start_busy: cover property (@(posedge i_clk) disable iff (i_reset)
      o_view.busy && i_start);

endmodule

// ===== hw/trim_swap_regs.sv
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - After reset each trim register shows its factory value, readable and rewritable.
// - The reference trim is a 4-bit field in bits 3:0, bits 7:4 reserved.
// - Four 8-bit termination trim registers exist, one per input channel A to D.
// - During a swap both cores sample the input for four plus twice the overlap delay.
// - The overlap delay field is 5 bits, 0 to 31, reset 8, bits 7:5 reserved.
// - The steer delay, 0 to 31 reset 7, delays the stream select during swaps only.
module trim_swap_regs
   import trim_swap_pkg::*;
#(
   parameter int ADR_W = 12,
   parameter int DLY_W = 5
) (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_reset,
   // Wishbone classic slave
   input  wire logic                  i_wb_cyc,
   input  wire logic                  i_wb_stb,
   input  wire logic                  i_wb_we,
   input  wire logic [ADR_W-1:0]      i_wb_adr,
   input  wire logic [31:0]           i_wb_dat,
   input  wire logic [3:0]            i_wb_sel,
   output      logic [31:0]           o_wb_dat,
   output      logic                  o_wb_ack,
   // Factory trim values
   input  wire trim_swap_pkg::trim_set_t i_fuse,
   // Swap request from calibration engine
   input  wire logic                  i_swap_start,
   // Settings to the analog and datapath
   output trim_swap_pkg::trim_set_t   o_trims,
   output      logic [7:0]            o_noise_injection_control,
   output      logic                  o_cal_enable,
   output trim_swap_pkg::swap_view_t  o_swap
);
   import trim_swap_pkg::*;

   initial begin
      if (ADR_W < 12) $error("ADR_W must cover address bits 11:2");
      if (DLY_W != DLY_FIELD_MSB + 1) $error("DLY_W must match the delay field");
   end

   ////////////////////////////////////////////////////////////////////////
   // Storage

   logic [7:0]       ref_trim_r;
   logic [7:0]       term_a_r;
   logic [7:0]       term_b_r;
   logic [7:0]       term_c_r;
   logic [7:0]       term_d_r;
   logic [7:0]       overlap_r;
   logic [7:0]       steer_r;
   logic [7:0]       noise_r;
   logic             cal_en_r;
   logic             load_pend_r;
   logic             ack_r;
   logic [31:0]      rdat_r;
   logic [31:0]      rdat_nxt;
   logic             req;
   logic             wr;
   logic [9:0]       idx;
   logic [7:0]       wbyte;
   swap_view_t       view;

   // Word index of the current request
   function automatic logic [9:0] word_index(input logic [ADR_W-1:0] adr);
      word_index = adr[11:2];
   endfunction

   // Address match against one register index
   function automatic logic hit(input logic [9:0] cur, input logic [9:0] tgt);
      hit = (cur == tgt);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   // No request is taken while the factory trims load
   assign req   = i_wb_cyc && i_wb_stb && !ack_r && !load_pend_r;
   assign wr    = req && i_wb_we && i_wb_sel[0];
   assign idx   = word_index(i_wb_adr);
   assign wbyte = i_wb_dat[7:0];

   // One-cycle acknowledge, dropped the cycle after
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Factory trim load

   // Fuse inputs are caught by the clock after release, not in reset
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         load_pend_r <= 1'b1;
      end else begin
         load_pend_r <= 1'b0;
      end
   end

   // Trim registers: fuse load first, software writes afterwards
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ref_trim_r <= RST_TRIM;
         term_a_r   <= RST_TRIM;
         term_b_r   <= RST_TRIM;
         term_c_r   <= RST_TRIM;
         term_d_r   <= RST_TRIM;
      end else if (load_pend_r) begin
         ref_trim_r <= {4'h0, i_fuse.reference};
         term_a_r   <= i_fuse.term_a;
         term_b_r   <= i_fuse.term_b;
         term_c_r   <= i_fuse.term_c;
         term_d_r   <= i_fuse.term_d;
      end else if (wr) begin
         // Reserved bits are stored as written so reads echo them
         if (hit(idx, IDX_REFERENCE_TRIM)) ref_trim_r <= wbyte;
         if (hit(idx, IDX_TERM_A_TRIM))    term_a_r   <= wbyte;
         if (hit(idx, IDX_TERM_B_TRIM))    term_b_r   <= wbyte;
         if (hit(idx, IDX_TERM_C_TRIM))    term_c_r   <= wbyte;
         if (hit(idx, IDX_TERM_D_TRIM))    term_d_r   <= wbyte;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Swap delays and control

   // Overlap delay is frozen while calibration runs, so a swap never
   // sees a half-changed length
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         overlap_r <= RST_OVERLAP;
      end else if (wr && hit(idx, IDX_SWAP_OVERLAP) && !cal_en_r) begin
         overlap_r <= wbyte;
      end
   end

   // Steer delay may change at any time; the timer latches it per swap
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         steer_r <= RST_STEER;
      end else if (wr && hit(idx, IDX_SWAP_STEER)) begin
         steer_r <= wbyte;
      end
   end

   // Noise injection settings pass straight to the datapath
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         noise_r <= RST_NOISE;
      end else if (wr && hit(idx, IDX_NOISE_INJ)) begin
         noise_r <= wbyte;
      end
   end

   // Calibration enable, which also locks the overlap delay
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cal_en_r <= 1'b0;
      end else if (wr && hit(idx, IDX_SWAP_CONTROL)) begin
         cal_en_r <= wbyte[CTRL_CAL_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux

   // Unmapped words read as zero and are still acknowledged
   always_comb begin
      rdat_nxt = '0;
      case (idx)
         IDX_REFERENCE_TRIM: rdat_nxt[7:0] = ref_trim_r;
         IDX_TERM_A_TRIM:    rdat_nxt[7:0] = term_a_r;
         IDX_TERM_B_TRIM:    rdat_nxt[7:0] = term_b_r;
         IDX_TERM_C_TRIM:    rdat_nxt[7:0] = term_c_r;
         IDX_TERM_D_TRIM:    rdat_nxt[7:0] = term_d_r;
         IDX_SWAP_OVERLAP:   rdat_nxt[7:0] = overlap_r;
         IDX_SWAP_STEER:     rdat_nxt[7:0] = steer_r;
         IDX_NOISE_INJ:      rdat_nxt[7:0] = noise_r;
         IDX_SWAP_CONTROL:   rdat_nxt[CTRL_CAL_EN_BIT] = cal_en_r;
         IDX_SWAP_STATUS: begin
            rdat_nxt[STAT_BUSY_BIT] = view.busy;
            rdat_nxt[STAT_OVL_BIT]  = view.overlap;
            rdat_nxt[STAT_SEL_BIT]  = view.steer_sel;
            rdat_nxt[STAT_LOCK_BIT] = cal_en_r;
         end
         default: rdat_nxt = '0;
      endcase
   end

   // Read data registered together with the acknowledge
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rdat_r <= '0;
      end else if (req) begin
         rdat_r <= i_wb_we ? '0 : rdat_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Swap timing

   swap_timer #(
      .DLY_W         (DLY_W)
   ) u_swap_timer (
      .i_clk         (i_clk),
      .i_reset       (i_reset),
      .i_start       (i_swap_start),
      .i_overlap_dly (overlap_r[DLY_FIELD_MSB:0]),
      .i_steer_dly   (steer_r[DLY_FIELD_MSB:0]),
      .o_view        (view)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_wb_ack                  = ack_r;
   assign o_wb_dat                  = rdat_r;
   assign o_trims.reference         = ref_trim_r[REF_FIELD_MSB:0];
   assign o_trims.term_a            = term_a_r;
   assign o_trims.term_b            = term_b_r;
   assign o_trims.term_c            = term_c_r;
   assign o_trims.term_d            = term_d_r;
   assign o_noise_injection_control = noise_r;
   assign o_cal_enable              = cal_en_r;
   assign o_swap                    = view;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   a_fuse_load_value: assert property (@(posedge i_clk) disable iff (i_reset)
      load_pend_r |=> (o_trims == $past(i_fuse)))
      else $error("trims do not hold the factory value after reset");
   a_ref_trim_field: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit(idx, IDX_REFERENCE_TRIM))
      |=> o_trims.reference == $past(i_wb_dat[REF_FIELD_MSB:0]))
      else $error("reference trim field not taken from bits 3:0");
   a_term_d_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit(idx, IDX_TERM_D_TRIM))
      |=> o_trims.term_d == $past(i_wb_dat[7:0]) && $stable(o_trims.term_a))
      else $error("channel D trim write went astray");
   a_overlap_locked: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit(idx, IDX_SWAP_OVERLAP) && cal_en_r) |=> $stable(overlap_r))
      else $error("overlap delay changed while calibration enabled");
   a_ack_one_cycle: assert property (@(posedge i_clk) disable iff (i_reset)
      req |=> o_wb_ack ##1 !o_wb_ack)
      else $error("acknowledge not a single cycle pulse");

   // Write paths: trims and delays take the bus byte (overlap only while unlocked), the enable takes bit 0; with lane 0 off nothing changes
   a_term_a_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit(idx, IDX_TERM_A_TRIM)) |=> o_trims.term_a == $past(wbyte))
      else $error("channel A trim write went astray");
   a_term_b_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit(idx, IDX_TERM_B_TRIM)) |=> o_trims.term_b == $past(wbyte))
      else $error("channel B trim write went astray");
   a_term_c_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit(idx, IDX_TERM_C_TRIM)) |=> o_trims.term_c == $past(wbyte))
      else $error("channel C trim write went astray");
   a_overlap_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit(idx, IDX_SWAP_OVERLAP) && !cal_en_r) |=> overlap_r == $past(wbyte))
      else $error("overlap delay write lost");
   a_steer_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit(idx, IDX_SWAP_STEER)) |=> steer_r == $past(wbyte))
      else $error("steer delay write lost");
   a_cal_enable_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit(idx, IDX_SWAP_CONTROL)) |=> o_cal_enable == $past(wbyte[CTRL_CAL_EN_BIT]))
      else $error("calibration enable write lost");
   a_lane_off_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (req && i_wb_we && !i_wb_sel[0]) |=> $stable(o_trims) && $stable(steer_r))
      else $error("write with lane 0 off changed a register");

   // Load and read paths; a read never races a write, so the register
   // seen one cycle on still holds the value that was read
   a_fuse_ref_reserved: assert property (@(posedge i_clk) disable iff (i_reset)
      load_pend_r |=> ref_trim_r[7:REF_FIELD_MSB+1] == '0)
      else $error("reserved reference bits not clear after load");
   a_ref_trim_read: assert property (@(posedge i_clk) disable iff (i_reset)
      (req && !i_wb_we && hit(idx, IDX_REFERENCE_TRIM))
      |=> o_wb_dat[REF_FIELD_MSB:0] == o_trims.reference)
      else $error("reference trim read back wrong");
   a_term_a_read: assert property (@(posedge i_clk) disable iff (i_reset)
      (req && !i_wb_we && hit(idx, IDX_TERM_A_TRIM)) |=> o_wb_dat == 32'(o_trims.term_a))
      else $error("channel A trim read back wrong");
   a_write_reads_zero: assert property (@(posedge i_clk) disable iff (i_reset)
      (req && i_wb_we) |=> o_wb_dat == '0)
      else $error("write acknowledge carried data");
   a_status_busy_bit: assert property (@(posedge i_clk) disable iff (i_reset)
      (req && !i_wb_we && hit(idx, IDX_SWAP_STATUS))
      |=> o_wb_dat[STAT_BUSY_BIT] == $past(view.busy))
      else $error("status busy bit differs from the swap timer");
   c_fuse_then_write: cover property (@(posedge i_clk) disable iff (i_reset)
      wr && hit(idx, IDX_REFERENCE_TRIM));
   c_status_read: cover property (@(posedge i_clk) disable iff (i_reset)
      req && !i_wb_we && hit(idx, IDX_SWAP_STATUS) && view.busy);

endmodule

// ===== verif/trim_and_core_swap_delay_regs_tb_top.sv
`timescale 1ns/1ps
module trim_and_core_swap_delay_regs_tb_top;
   import trim_swap_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // One register access and the value it should read back
   typedef struct packed {
      logic [9:0] idx;
      logic [7:0] wr;
      logic [7:0] rd;
   } row_t;

   // Factory trims, arbitrary but all fields distinct
   localparam trim_set_t FUSE  = {4'hA, 8'h5C, 8'hA3, 8'h3E, 8'hC1};
   localparam int        LIMIT = 20000;

   logic       i_clk;
   logic       i_reset;
   logic       i_wb_cyc;
   logic       i_wb_stb;
   logic       i_wb_we;
   logic [11:0] i_wb_adr;
   logic [31:0] i_wb_dat;
   logic [3:0] i_wb_sel;
   logic [31:0] o_wb_dat;
   logic       o_wb_ack;
   logic       i_swap_start;
   trim_set_t  o_trims;
   logic [7:0] o_noise_injection_control;
   logic       o_cal_enable;
   swap_view_t o_swap;
   int         bad_count;
   int         num_checks;
   int         cycles;
   logic [31:0] rdat;
   row_t       rows [9];
   int         ov_tab [4];
   int         st_tab [4];

   trim_swap_regs uut (
      .i_clk                     (i_clk),
      .i_reset                   (i_reset),
      .i_wb_cyc                  (i_wb_cyc),
      .i_wb_stb                  (i_wb_stb),
      .i_wb_we                   (i_wb_we),
      .i_wb_adr                  (i_wb_adr),
      .i_wb_dat                  (i_wb_dat),
      .i_wb_sel                  (i_wb_sel),
      .o_wb_dat                  (o_wb_dat),
      .o_wb_ack                  (o_wb_ack),
      .i_fuse                    (FUSE),
      .i_swap_start              (i_swap_start),
      .o_trims                   (o_trims),
      .o_noise_injection_control (o_noise_injection_control),
      .o_cal_enable              (o_cal_enable),
      .o_swap                    (o_swap)
   );

   ////////////////////////////////////////////////////////////////////////
   // Clock at 200 MHz and a hang guard
   always #2.5 i_clk = ~i_clk;

   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         bad_count++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare, report and finish
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Classic Wishbone cycle; waits on ack, the guard ends a hang
   task automatic wb_cycle(input logic [9:0] idx, input logic we, input logic [7:0] d,
                           input logic [3:0] sel, output logic [31:0] q);
      @(posedge i_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we  <= we;
      i_wb_adr <= {idx, 2'b00};
      i_wb_dat <= {24'h000000, d};
      i_wb_sel <= sel;
      do @(posedge i_clk); while (o_wb_ack !== 1'b1);
      q = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we  <= 1'b0;
   endtask

   task automatic wb_wr(input logic [9:0] idx, input logic [7:0] d);
      logic [31:0] q;
      wb_cycle(idx, 1'b1, d, 4'h1, q);
   endtask

   task automatic wb_rd(input logic [9:0] idx, output logic [31:0] q);
      wb_cycle(idx, 1'b0, 8'h00, 4'h1, q);
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp, input string msg);
      logic [31:0] q;
      wb_rd(idx, q);
      chk_val(q, {24'h000000, exp}, msg);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Values seen right after any reset
   task automatic check_defaults();
      rd_chk(IDX_REFERENCE_TRIM, {4'h0, FUSE.reference}, "ref fuse");
      rd_chk(IDX_TERM_A_TRIM, FUSE.term_a, "term a fuse");
      rd_chk(IDX_TERM_B_TRIM, FUSE.term_b, "term b fuse");
      rd_chk(IDX_TERM_C_TRIM, FUSE.term_c, "term c fuse");
      rd_chk(IDX_TERM_D_TRIM, FUSE.term_d, "term d fuse");
      rd_chk(IDX_SWAP_OVERLAP, 8'h08, "overlap reset");
      rd_chk(IDX_SWAP_STEER, 8'h07, "steer reset");
      rd_chk(IDX_NOISE_INJ, 8'h00, "noise reset");
      chk_val(32'(o_trims.reference), 32'(FUSE.reference), "ref out");
      chk_val(o_trims[31:0], FUSE[31:0], "term trim outputs");
      chk_val(32'(o_swap), 32'h0, "swap idle");
   endtask

   task automatic do_reset(input int n);
      i_reset <= 1'b1;
      repeat (n) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // One swap: overlap length, steer moment, busy span, second start ignored
   task automatic run_swap(input int ov, input int st);
      int   ovl_n;
      int   busy_n;
      int   flip;
      int   exp_busy;
      logic sel0;
      ovl_n  = 0;
      busy_n = 0;
      flip   = -1;
      wb_wr(IDX_SWAP_OVERLAP, 8'(ov));  // calibration enable is clear here
      wb_wr(IDX_SWAP_STEER, 8'(st));
      @(posedge i_clk);
      sel0 = o_swap.steer_sel;
      i_swap_start <= 1'b1;
      @(posedge i_clk);
      i_swap_start <= 1'b0;
      for (int k = 0; k < 80; k++) begin
         #1;
         if (k == 0) chk_val({30'h0, o_swap.busy, o_swap.overlap}, 32'h3, "swap answer");
         ovl_n  += (o_swap.overlap === 1'b1);
         busy_n += (o_swap.busy === 1'b1);
         if (flip < 0 && o_swap.steer_sel !== sel0) flip = k;
         @(posedge i_clk);
         i_swap_start <= (k == 1);
      end
      exp_busy = (4 + 2 * ov > st + 1) ? 4 + 2 * ov : st + 1;
      chk_val(32'(ovl_n), 32'(4 + 2 * ov), "overlap length");
      chk_val(32'(flip), 32'(st + 1), "steer moment");
      chk_val(32'(busy_n), 32'(exp_busy), "busy span");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      i_clk        = 1'b0;
      i_reset      = 1'b1;
      i_wb_cyc     = 1'b0;
      i_wb_stb     = 1'b0;
      i_wb_we      = 1'b0;
      i_wb_adr     = 12'h000;
      i_wb_dat     = 32'h00000000;
      i_wb_sel     = 4'h0;
      i_swap_start = 1'b0;
      bad_count    = 0;
      num_checks   = 0;
      cycles       = 0;
      rows = '{{IDX_REFERENCE_TRIM, 8'h06, 8'h06}, {IDX_TERM_A_TRIM, 8'hFF, 8'hFF},
               {IDX_TERM_B_TRIM, 8'h00, 8'h00}, {IDX_TERM_C_TRIM, 8'h81, 8'h81},
               {IDX_TERM_D_TRIM, 8'h7E, 8'h7E}, {IDX_SWAP_OVERLAP, 8'h1F, 8'h1F},
               {IDX_SWAP_STEER, 8'h00, 8'h00}, {IDX_NOISE_INJ, 8'h05, 8'h05},
               {10'h07D, 8'h5A, 8'h00}};
      ov_tab = '{0, 31, 3, 7};
      // Switch inside the overlap except the last row, which steers late
      st_tab = '{1, 31, 0, 20};
      repeat (16) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_clk);
      check_defaults();
      // Reserved bits are always written as zero by software
      foreach (rows[i]) begin
         wb_wr(rows[i].idx, rows[i].wr);
         rd_chk(rows[i].idx, rows[i].rd, "row readback");
      end
      chk_val(32'(o_trims.reference), 32'h00000006, "ref trim out");
      chk_val(o_trims[31:0], 32'hFF00817E, "term trims out");
      chk_val(32'(o_noise_injection_control), 32'h05, "noise out");
      // Lane 0 not selected: write is acked and dropped
      wb_cycle(IDX_TERM_A_TRIM, 1'b1, 8'h11, 4'hE, rdat);
      chk_val(rdat, 32'h00000000, "write returns zero");
      rd_chk(IDX_TERM_A_TRIM, 8'hFF, "sel0 low write");
      // Overlap delay is frozen while calibration runs
      wb_wr(IDX_SWAP_CONTROL, 8'h01);
      chk_val(32'(o_cal_enable), 32'h1, "cal enable set");
      rd_chk(IDX_SWAP_CONTROL, 8'h01, "control readback");
      // Idle, select still at reset: only the lock bit shows
      rd_chk(IDX_SWAP_STATUS, 8'(1 << STAT_LOCK_BIT), "status locked");
      wb_wr(IDX_SWAP_OVERLAP, 8'h03);
      rd_chk(IDX_SWAP_OVERLAP, 8'h1F, "overlap locked");
      wb_wr(IDX_SWAP_CONTROL, 8'h00);
      chk_val(32'(o_cal_enable), 32'h0, "cal enable clear");
      foreach (ov_tab[i]) run_swap(ov_tab[i], st_tab[i]);
      // Status read in a swap; four flips left the select back at zero
      @(posedge i_clk);
      i_swap_start <= 1'b1;
      @(posedge i_clk);
      i_swap_start <= 1'b0;
      rd_chk(IDX_SWAP_STATUS, 8'((1 << STAT_BUSY_BIT) | (1 << STAT_OVL_BIT)), "status busy");
      // Reset in mid-run brings back factory trims and defaults
      do_reset(3);
      check_defaults();
      end_sim();
   end

endmodule
